// ---- interrupt_priority_arbitration_tb.sv ----
/* Self-checking bench for irq_arb.
   Assumes irq_dev_model and the bound checker. */
`timescale 1ns/1ps
module interrupt_priority_arbitration_tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         tmr = 1'b0;
   reg         ib = 1'b1;
   reg         go = 1'b0;
   reg  [2:0]  lvl = 3'h1;
   reg  [1:0]  mode = 2'h0;
   reg  [3:0]  dly = 4'h0;
   reg  [7:0]  vec = 8'h00;
   reg         wide = 1'b0;
   wire [31:0] prdata;
   wire        pready, slverr, act, strb_n, autovec_n, bus_err, vv;
   wire [7:1]  irq_n;
   wire [15:0] din;
   wire [1:0]  tack_n;
   wire [23:0] addr;
   wire [7:0]  vout;
   reg  [27:0] rows [0:5];
   reg  [31:0] rd;
   reg  [9:0]  ex;
   reg  [7:0]  vq;
   reg         seen;
   integer     n, i;
   integer     error_cnt = 0;
   integer     total_checks = 0;
   irq_arb #(.MON_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(slverr), .irq_n(irq_n), .periodic_timer(tmr),
      .instr_boundary(ib), .ext_contend(16'h0000), .data_in(din), .port_16bit(wide),
      .transfer_acknowledge_n(tack_n), .autovector_request_n(autovec_n),
      .ext_bus_error_n(1'b1), .ack_active(act), .ack_addr(addr),
      .function_code_lines(), .transfer_size_lines(), .read_write(), .ack_strobe_n(strb_n),
      .bus_error_signal(bus_err), .vector_out(vout), .vector_valid(vv));
   irq_dev_model i_dev (.pclk(pclk), .presetn(presetn), .go(go), .level(lvl), .mode(mode),
      .delay(dly), .vec(vec), .wide(wide), .ack_active(act), .ack_addr(addr),
      .ack_strobe_n(strb_n), .irq_n(irq_n), .data_in(din), .transfer_acknowledge_n(tack_n),
      .autovector_request_n(autovec_n));
   always #2 pclk = ~pclk;
   task chk(input [31:0] s, input [31:0] e);
      total_checks = total_checks + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task go_pulse;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
   endtask
   task vwait;
      n = 0;
      while (vv !== 1'b1 && bus_err !== 1'b1 && n < 300) begin
         @(negedge pclk);
         n = n + 1;
      end
      vq = vout;
      chk(n < 300, 1);
      @(posedge pclk);
   endtask
   task quiet;
      seen = 1'b0;
      repeat (40) begin
         @(negedge pclk);
         seen = seen | act;
      end
      chk(seen, 0);
      @(posedge pclk);
   endtask
   task report_and_stop;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
   initial begin
      // Level, mode, port width, delay, vector, then {result, expected vector}
      rows[0] = {3'h1, 2'h0, 1'b0, 4'h0, 8'hA5, 10'h1A5};
      rows[1] = {3'h4, 2'h0, 1'b1, 4'h5, 8'h3C, 10'h13C};
      rows[2] = {3'h6, 2'h1, 1'b0, 4'h2, 8'h00, 10'h21E};
      rows[3] = {3'h2, 2'h2, 1'b0, 4'h0, 8'h00, 10'h30F};
      rows[4] = {3'h3, 2'h3, 1'b0, 4'h0, 8'h00, 10'h143};
      rows[5] = {3'h7, 2'h0, 1'b1, 4'h1, 8'h7E, 10'h17E};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 6; i = i + 1) begin
         {lvl, mode, wide, dly, vec} <= rows[i][27:10];
         ex = rows[i][9:0];
         apb(1'b1, 12'h00C, 32'h0);
         if (rows[i][24:23] == 2'h3) begin
            apb(1'b1, 12'h004, {29'h0, rows[i][27:25]});
            tmr <= 1'b1;
         end else
            go_pulse;
         vwait;
         tmr <= 1'b0;
         chk(vq, ex[7:0]);
         apb(1'b0, 12'h014, 32'h0);
         chk(rd[9:0], ex);
      end
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'hF);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h7);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      chk(slverr, 1'b0);
      apb(1'b1, 12'h004, 32'h3);
      tmr <= 1'b1;
      quiet;
      {lvl, mode, wide, vec} <= {3'h7, 2'h0, 1'b1, 8'h77};
      go_pulse;
      vwait;
      chk(vq, 8'h77);
      ib <= 1'b0;
      apb(1'b1, 12'h00C, 32'h2);
      quiet;
      ib <= 1'b1;
      vwait;
      tmr <= 1'b0;
      chk(vq, 8'h43);
      apb(1'b1, 12'h004, 32'h5);
      apb(1'b1, 12'h00C, 32'h7);
      {lvl, mode} <= {3'h5, 2'h1};
      tmr <= 1'b1;
      go_pulse;
      repeat (8) @(posedge pclk);
      apb(1'b1, 12'h00C, 32'h0);
      vwait;
      tmr <= 1'b0;
      chk(vq, 8'h45);
      apb(1'b1, 12'h00C, 32'h0);
      vwait;
      chk(vq, 8'h1D);
      apb(1'b1, 12'h000, 32'h7);
      {lvl, mode} <= {3'h6, 2'h2};
      go_pulse;
      vwait;
      chk(vq, 8'h1E);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h00C, 32'h0);
      tmr <= 1'b1;
      quiet;
      tmr <= 1'b0;
      apb(1'b1, 12'h008, 32'h0);
      {lvl, mode} <= {3'h2, 2'h0};
      go_pulse;
      vwait;
      chk(vq, 8'h0F);
      report_and_stop;
   end
endmodule // interrupt_priority_arbitration_tb

// ---- irq_arb.v ----
/*
 * Interrupt request sampling, masking, arbitration and acknowledge cycle,
 * with an APB register slave. Assumes request pins are asynchronous and
 * that the processor side reports instruction boundaries on one input.
 */
`timescale 1ns/1ps
`include "irq_arb_defines.vh"
module irq_arb #(
   parameter MON_CYCLES = `MON_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [7:1]  irq_n,
   input  wire        periodic_timer,
   input  wire        instr_boundary,
   input  wire [15:0] ext_contend,
   input  wire [15:0] data_in,
   input  wire        port_16bit,
   input  wire [1:0]  transfer_acknowledge_n,
   input  wire        autovector_request_n,
   input  wire        ext_bus_error_n,
   output reg         ack_active,
   output reg  [23:0] ack_addr,
   output reg  [2:0]  function_code_lines,
   output reg  [1:0]  transfer_size_lines,
   output reg         read_write,
   output reg         ack_strobe_n,
   output reg         bus_error_signal,
   output reg  [7:0]  vector_out,
   output reg         vector_valid
);
   localparam S_IDLE = 3'h0;
   localparam S_ARB  = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_DONE = 3'h3;

   reg  [7:1] s1, s2, s3;
   reg  [7:1] valid;
   reg        l7_prev;
   reg        nmi_pend;
   reg  [2:0] mask;
   reg  [2:0] mask_prev;
   reg  [2:0] ctrl;
   reg  [2:0] timer_request_level;
   reg  [3:0] arbitration_priority_field;
   reg  [2:0] state;
   reg  [2:0] level;
   reg        from_timer;
   reg  [1:0] bit_idx;
   reg  [3:0] arb_won;
   reg        contend_ok;
   reg  [9:0] mon_cnt;
   reg  [1:0] result;
   reg  [7:0] last_vector;
   integer    i;

   // Highest pending level and its source
   reg  [2:0] pick;
   reg        pick_timer;
   always @* begin
      pick = 3'h0;
      pick_timer = 1'b0;
      for (i = 1; i <= 7; i = i + 1) begin
         if (i[2:0] > mask || i == 7) begin
            if ((i == 7) ? nmi_pend : valid[i]) begin
               pick = i[2:0];
               pick_timer = 1'b0;
            end
            if (periodic_timer && timer_request_level == i[2:0]
                && timer_request_level != 3'h0) begin
               pick = i[2:0];
               pick_timer = 1'b1;
            end
         end
      end
   end

   // Own field bit in the current contention round, MSB first
   wire own_bit = arbitration_priority_field[3 - bit_idx];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 7'h7F;
         s2 <= 7'h7F;
         s3 <= 7'h7F;
         valid <= 7'h00;
         l7_prev <= 1'b0;
         nmi_pend <= 1'b0;
         mask_prev <= `MASK_RESET;
      end else begin
         s1 <= irq_n;
         s2 <= s1;
         s3 <= s2;
         valid <= ~s2 & ~s3;
         l7_prev <= valid[7];
         mask_prev <= mask;
         if ((valid[7] && !l7_prev) ||
             (valid[7] && mask_prev == 3'h7 && mask != 3'h7)) begin
            nmi_pend <= 1'b1;
         end else if (state == S_ARB && level == 3'h7 && !from_timer) begin
            nmi_pend <= 1'b0;
         end
      end
   end

   wire wr = psel && penable && pwrite;
   wire in_ack = (state != S_IDLE);
   wire ext_ack = ~(&transfer_acknowledge_n);
   wire ext_av  = ~autovector_request_n;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         level <= 3'h0;
         from_timer <= 1'b0;
         bit_idx <= 2'h0;
         contend_ok <= 1'b0;
         mon_cnt <= 10'h000;
         mask <= `MASK_RESET;
         ctrl <= `CTRL_RESET;
         timer_request_level <= 3'h0;
         arbitration_priority_field <= `ARB_RESET;
         ack_active <= 1'b0;
         ack_addr <= 24'h000000;
         function_code_lines <= 3'h0;
         transfer_size_lines <= 2'h0;
         read_write <= 1'b1;
         ack_strobe_n <= 1'b1;
         bus_error_signal <= 1'b0;
         vector_out <= 8'h00;
         vector_valid <= 1'b0;
         result <= 2'h0;
         last_vector <= 8'h00;
      end else begin
         vector_valid <= 1'b0;
         bus_error_signal <= 1'b0;
         if (wr && paddr == `REG_CTRL)
            ctrl <= pwdata[2:0];
         if (wr && paddr == `REG_TIMER_LEVEL)
            timer_request_level <= pwdata[2:0];
         if (wr && paddr == `REG_ARB_FIELD)
            arbitration_priority_field <= pwdata[3:0];
         if (wr && paddr == `REG_MASK && !in_ack)
            mask <= pwdata[2:0];
         case (state)
            S_IDLE: begin
               if (instr_boundary && pick != 3'h0) begin
                  state <= S_ARB;
                  level <= pick;
                  from_timer <= pick_timer;
                  mask <= pick;
                  bit_idx <= 2'h0;
                  contend_ok <= 1'b0;
                  ack_active <= 1'b1;
                  function_code_lines <= `FC_CPU_SPACE;
                  ack_addr <= {`ACK_ADDR_HI, pick, 1'b1};
                  transfer_size_lines <= `SIZE_BYTE;
                  read_write <= 1'b1;
               end
            end
            S_ARB: begin
               // Own field contends only if a source here holds this level
               if (own_bit && (from_timer || valid[level] || level == 3'h7))
                  contend_ok <= 1'b1;
               bit_idx <= bit_idx + 2'h1;
               if (bit_idx == 2'h3) begin
                  mon_cnt <= 10'h000;
                  if (!(contend_ok || (own_bit && (from_timer || valid[level]
                        || level == 3'h7)))) begin
                     bus_error_signal <= 1'b1;
                     vector_out <= `SPURIOUS_VEC;
                     vector_valid <= 1'b1;
                     result <= 2'h3;
                     state <= S_DONE;
                  end else if (from_timer) begin
                     vector_out <= {5'h08, level};
                     vector_valid <= 1'b1;
                     result <= 2'h1;
                     state <= S_DONE;
                  end else begin
                     ack_strobe_n <= 1'b0;
                     state <= S_WAIT;
                  end
               end
            end
            S_WAIT: begin
               mon_cnt <= mon_cnt + 10'h001;
               if (ext_av || (ctrl[`CTRL_CS_EN] && ctrl[`CTRL_CS_AUTO])) begin
                  vector_out <= `AUTOVEC_BASE + {5'h00, level};
                  vector_valid <= 1'b1;
                  result <= 2'h2;
                  state <= S_DONE;
               end else if (ext_ack) begin
                  vector_out <= port_16bit ? data_in[7:0] : data_in[15:8];
                  vector_valid <= 1'b1;
                  result <= 2'h1;
                  state <= S_DONE;
               end else if (!ext_bus_error_n ||
                            (ctrl[`CTRL_MON_EN] && mon_cnt == MON_CYCLES[9:0])) begin
                  bus_error_signal <= 1'b1;
                  vector_out <= `SPURIOUS_VEC;
                  vector_valid <= 1'b1;
                  result <= 2'h3;
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               last_vector <= vector_out;
               ack_active <= 1'b0;
               ack_strobe_n <= 1'b1;
               function_code_lines <= 3'h0;
               ack_addr <= 24'h000000;
               transfer_size_lines <= 2'h0;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Read data latched at the setup edge, stands through the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            `REG_CTRL:        prdata <= {29'h0, ctrl};
            `REG_TIMER_LEVEL: prdata <= {29'h0, timer_request_level};
            `REG_ARB_FIELD:   prdata <= {28'h0, arbitration_priority_field};
            `REG_MASK:        prdata <= {29'h0, mask};
            `REG_STATUS:      prdata <= {22'h0, nmi_pend, valid, ack_active, from_timer};
            `REG_VECTOR:      prdata <= {22'h0, result, last_vector};
            `REG_SERVICE:     prdata <= {29'h0, level};
            `REG_ACK_ADDR:    prdata <= {8'h0, ack_addr};
            default:          prdata <= 32'h00000000;
         endcase
      end
   end
endmodule // irq_arb

// ---- irq_arb_asserts.sv ----
/* Port checker for irq_arb.
   Bound to every irq_arb; sees its ports only. */
`timescale 1ns/1ps
module irq_arb_asserts #(
   parameter MON_CYCLES = 64
) (
   input wire        pclk,
   input wire        presetn,
   input wire [15:0] data_in,
   input wire        port_16bit,
   input wire [1:0]  transfer_acknowledge_n,
   input wire        autovector_request_n,
   input wire        ack_active,
   input wire [23:0] ack_addr,
   input wire [2:0]  function_code_lines,
   input wire [1:0]  transfer_size_lines,
   input wire        read_write,
   input wire        ack_strobe_n,
   input wire        bus_error_signal,
   input wire [7:0]  vector_out,
   input wire        vector_valid
);
   reg [7:0] wait_cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wait_cnt <= 8'h00;
      else
         wait_cnt <= ack_strobe_n ? 8'h00 : wait_cnt + 8'h01;
   end
   // Vector byte as it stood at the previous edge
   reg [7:0] dbyte;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dbyte <= 8'h00;
      else
         dbyte <= port_16bit ? data_in[7:0] : data_in[15:8];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_func_code; ack_active |-> function_code_lines == 3'h7; endproperty
   a_func_code: assert property (p_func_code) else $error("bad function code");
   property p_addr; ack_active |-> ack_addr[23:4] == 20'hFFFFF && ack_addr[0]; endproperty
   a_addr: assert property (p_addr) else $error("bad addr");
   property p_size; ack_active |-> transfer_size_lines == 2'h1 && read_write; endproperty
   a_size: assert property (p_size) else $error("bad size");
   property p_vv; vector_valid |=> !vector_valid; endproperty
   a_vv: assert property (p_vv) else $error("long valid");
   property p_bus_err; bus_error_signal |-> ##[0:1] vector_out == 8'h0F; endproperty
   a_bus_err: assert property (p_bus_err) else $error("bad spurious");
   property p_mon; !ack_strobe_n |-> wait_cnt <= MON_CYCLES + 3; endproperty
   a_mon: assert property (p_mon) else $error("no timeout");
   property p_autovec;
      $fell(autovector_request_n) && !ack_strobe_n
         |-> ##1 vector_valid && vector_out == 8'h18 + {5'h00, ack_addr[3:1]};
   endproperty
   a_autovec: assert property (p_autovec) else $error("bad autovector");
   property p_dack;
      $fell(&transfer_acknowledge_n) && !ack_strobe_n
         |-> ##1 vector_valid && vector_out == dbyte;
   endproperty
   a_dack: assert property (p_dack) else $error("bad vector");
   c_vec: cover property (vector_valid);
   c_bus_err: cover property (bus_error_signal);
   c_autovec: cover property ($fell(autovector_request_n));
endmodule // irq_arb_asserts
bind irq_arb irq_arb_asserts #(.MON_CYCLES(MON_CYCLES)) i_chk (.pclk, .presetn,
   .data_in, .port_16bit, .transfer_acknowledge_n, .autovector_request_n, .ack_active,
   .ack_addr, .function_code_lines, .transfer_size_lines, .read_write, .ack_strobe_n,
   .bus_error_signal, .vector_out, .vector_valid);

// ---- irq_arb_defines.vh ----
/*
 * Constants for the interrupt priority and arbitration block.
 * Assumes inclusion by the single design file; definitions only.
 */
`ifndef IRQ_ARB_DEFINES_VH
`define IRQ_ARB_DEFINES_VH
// Functional notes
// - Seven low lines map to levels one..seven
// - Timer level field; zero disables timer
// - Ignore requests at or below mask
// - Level seven always recognized, non-maskable
// - Highest simultaneous level wins
// - Timer beats same-level line; line stays pending
// - Level seven on edge or mask drop
// - Valid after two consecutive asserted samples
// - Pending requests serviced at instruction boundary
// - Level not latched; higher one served first
// - Start CPU-space read, load level into mask
// - Serial four-bit contention; zero means spurious
// - Own field resets 1111, others 0000
// - Always arbitrate; external only if we win
// - Function code 111, address ones, byte read
// - Winner gives vector with acknowledge, or autovector
// - No contender or timeout gives bus error
// - Chip select may answer acknowledge or autovector; here it only autovectors, with CTRL_CS_EN and CTRL_CS_AUTO both set
// - Autovector excludes acknowledge; vector from level

// Register byte offsets
`define REG_CTRL        12'h000
`define REG_TIMER_LEVEL 12'h004
`define REG_ARB_FIELD   12'h008
`define REG_MASK        12'h00C
`define REG_STATUS      12'h010
`define REG_VECTOR      12'h014
`define REG_SERVICE     12'h018
`define REG_ACK_ADDR    12'h01C

// Control register bits
`define CTRL_MON_EN  0
`define CTRL_CS_EN   1
`define CTRL_CS_AUTO 2

// Reset values
`define CTRL_RESET   3'h1
`define ARB_RESET    4'hF
`define MASK_RESET   3'h7

// Acknowledge cycle encodings
`define FC_CPU_SPACE 3'h7
`define ACK_ADDR_HI  20'hFFFFF
`define SIZE_BYTE    2'h1
`define SPURIOUS_VEC 8'h0F
`define AUTOVEC_BASE 8'h18

// Bus monitor time in ns and derived cycles at 4 ns
`define MON_TIME_NS  256
`define CLK_PERIOD_NS 4
`define MON_CYCLES   (`MON_TIME_NS / `CLK_PERIOD_NS)
`endif

// ---- irq_dev_model.sv ----
/* External interrupting device model.
   Assumes one requester; mode 0 vector, 1 autovector, 2 silent. */
`timescale 1ns/1ps
module irq_dev_model (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        go,
   input  wire [2:0]  level,
   input  wire [1:0]  mode,
   input  wire [3:0]  delay,
   input  wire [7:0]  vec,
   input  wire        wide,
   input  wire        ack_active,
   input  wire [23:0] ack_addr,
   input  wire        ack_strobe_n,
   output reg  [7:1]  irq_n,
   output reg  [15:0] data_in,
   output reg  [1:0]  transfer_acknowledge_n,
   output reg         autovector_request_n
);
   reg       pend;
   reg [3:0] cnt;
   wire      mine = ack_addr[3:1] == level;
   wire      ans  = !ack_strobe_n && mine && cnt == delay;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         cnt <= 4'h0;
         irq_n <= 7'h7F;
         data_in <= 16'h0000;
         transfer_acknowledge_n <= 2'b11;
         autovector_request_n <= 1'b1;
      end else begin
         if (go)
            pend <= 1'b1;
         else if (!ack_strobe_n && mine)
            pend <= 1'b0;
         irq_n <= ~(pend ? 7'h01 << (level - 3'h1) : 7'h00);
         cnt <= ack_strobe_n ? 4'h0 : cnt + {3'h0, cnt != delay};
         transfer_acknowledge_n <= ans && mode == 2'h0 ? {~wide, 1'b0} : 2'b11;
         autovector_request_n <= ~(ans && mode == 2'h1);
         // Released bus toggles so stale data never matches
         data_in <= ans && mode == 2'h0 ? (wide ? {~vec, vec} : {vec, ~vec}) : ~data_in;
      end
   end
endmodule // irq_dev_model
